//--- rtl/timer8_core.sv
// 8-bit timer/counter: normal and clear-on-match counting with compare unit
//
// Function
// - New output mode applies at next match.
// - Force strobe applies output action immediately in non-PWM modes; PWM modes ignore it.
// - Waveform mode and compare A (as top) steer counting.
// - Output mode picks set/clear/toggle or polarity.
// - Mode 0 counts up, wraps FF to 00.
// - Overflow flag set on a normal-mode tick wrap to zero and at the dual-slope bottom turn.
// - Flag set by hardware, cleared by acknowledge.
// - Counter writable anytime in normal mode.
// - Mode 2 clears counter on match A.
// - Compare A is top in clear mode.
// - Compare match raises an interrupt request.
`timescale 1ns/1ps
`default_nettype none
module timer8_core
    import timer8_pkg::*;
(
    input  wire logic        i_clk,      // 200 MHz system clock
    input  wire logic        i_rst_n,    // Async reset, active low
    input  wire logic        i_tick,     // Prescaler tick, same domain
    input  wire timer_ctrl_t i_ctrl,     // Configuration and strobes
    output var timer_stat_t  o_stat,     // Count, flags, pin
    output logic             o_ovf_irq,  // Overflow interrupt request
    output logic             o_cmp_irq   // Compare match interrupt request
);

    // All core state in one register, filled by one combinational copy
    typedef struct packed {
        logic [7:0] count;
        logic       up;
        logic       ovf;
        logic       cmpf;
    } core_state_t;

    core_state_t st;
    core_state_t next_st;
    logic        match;
    logic        pwm;
    logic        cmp_pin;
    logic [7:0]  top;

    // Mode decode used for pwm flag and direction forcing
    function automatic logic is_pwm(input logic [2:0] m);
        is_pwm = (m != WGM_NORMAL) && (m != WGM_CLEAR);
    endfunction

    // Top is compare A where it sets the period, otherwise the maximum
    function automatic logic [7:0] top_of(input logic [2:0] m, input logic [7:0] a);
        top_of = (m == WGM_CLEAR || m == WGM_PC_TOP || m == WGM_FAST_TOP) ? a : CNT_MAX;
    endfunction

    // Mode decodes shared by counting and the output unit
    assign pwm   = is_pwm(i_ctrl.wave_gen_mode);
    assign top   = top_of(i_ctrl.wave_gen_mode, i_ctrl.cmp_value_a);
    // Match is qualified by the tick so one compare gives one event
    assign match = i_tick && (st.count == i_ctrl.cmp_value_a);

    // Next-state: counting sequence depends on wave_gen_mode and top (compare A)
    always_comb
    begin
        next_st = st;
        if (i_tick)
        begin
            unique case (i_ctrl.wave_gen_mode)
                WGM_NORMAL:
                    next_st.count = st.count + 8'h01;
                WGM_CLEAR:
                    next_st.count = (st.count == top) ? CNT_BOTTOM
                                                      : st.count + 8'h01;
                WGM_PC_FF, WGM_PC_TOP:
                begin
                    // Dual slope: turn at top and at bottom
                    if (st.up && st.count == top)
                    begin
                        next_st.up    = 1'b0;
                        next_st.count = st.count - 8'h01;
                    end
                    else if (!st.up && st.count == CNT_BOTTOM)
                    begin
                        next_st.up    = 1'b1;
                        next_st.count = st.count + 8'h01;
                    end
                    else
                        next_st.count = st.up ? st.count + 8'h01 : st.count - 8'h01;
                end
                default:
                    next_st.count = (st.count == top) ? CNT_BOTTOM : st.count + 8'h01;
            endcase
            if (!is_pwm(i_ctrl.wave_gen_mode))
                next_st.up = 1'b1;
        end
        // Software write wins over counting, accepted in any cycle
        if (i_ctrl.count_wr)
            next_st.count = i_ctrl.count_wr_data;
        // Acknowledge clears, but a new overflow in the same cycle wins
        if (i_ctrl.overflow_ack)
            next_st.ovf = 1'b0;
        // Only a normal-mode tick wrap or a dual-slope bottom turn overflows; a written zero is no overflow
        if (i_tick && !i_ctrl.count_wr && next_st.count == CNT_BOTTOM
            && st.count != CNT_BOTTOM && i_ctrl.wave_gen_mode == WGM_NORMAL)
            next_st.ovf = 1'b1;
        else if (i_tick && !i_ctrl.count_wr && pwm && !st.up && next_st.up)
            next_st.ovf = 1'b1;
        // Compare flag keeps the same set-over-clear order
        if (i_ctrl.overflow_ack)
            next_st.cmpf = 1'b0;
        if (match)
            next_st.cmpf = 1'b1;
    end

    // Reset leaves the counter at bottom and counting up
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st       <= '0;
            st.count <= CNT_RST;
            st.up    <= 1'b1;
        end
        else
            st <= next_st;
    end

    // Output unit only sees tick-qualified matches
    timer8_out_unit u_out (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pwm   (pwm),
        .i_mode  (i_ctrl.cmp_out_mode),
        .i_match (match),
        .i_force (i_ctrl.force_cmp_strobe),
        .i_up    (st.up),
        .o_pin   (cmp_pin)
    );

    // Status and interrupt outputs are straight from flip-flops
    always_comb
    begin
        o_stat.count_value    = st.count;
        o_stat.overflow_flag  = st.ovf;
        o_stat.cmp_match_flag = st.cmpf;
        o_stat.cmp_out        = cmp_pin;
    end
    assign o_ovf_irq             = st.ovf;
    assign o_cmp_irq             = st.cmpf;

    // Checks on the counting sequence and the flags
    a_normal_wraps: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_tick && !i_ctrl.count_wr && i_ctrl.wave_gen_mode == WGM_NORMAL
         && st.count == CNT_MAX) |=> (o_stat.count_value == CNT_BOTTOM))
        else $error("normal mode did not wrap to zero");

    a_normal_increments: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_tick && !i_ctrl.count_wr && i_ctrl.wave_gen_mode == WGM_NORMAL)
        |=> (o_stat.count_value == $past(st.count) + 8'h01))
        else $error("normal mode did not increment");

    a_ovf_with_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_tick && !i_ctrl.count_wr && i_ctrl.wave_gen_mode == WGM_NORMAL
         && st.count == CNT_MAX) |=> o_stat.overflow_flag)
        else $error("overflow flag not set with zero count");

    a_ovf_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_stat.overflow_flag && !i_ctrl.overflow_ack) |=> o_stat.overflow_flag)
        else $error("overflow flag cleared without acknowledge");

    a_count_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_ctrl.count_wr |=> (o_stat.count_value == $past(i_ctrl.count_wr_data)))
        else $error("counter write not accepted");

    a_clear_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_tick && !i_ctrl.count_wr && i_ctrl.wave_gen_mode == WGM_CLEAR
         && st.count == i_ctrl.cmp_value_a) |=> (o_stat.count_value == CNT_BOTTOM))
        else $error("clear mode did not clear on match");

    a_hold_no_tick: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_tick && !i_ctrl.count_wr) |=> $stable(o_stat.count_value))
        else $error("counter moved without tick");

    a_match_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        match |=> o_cmp_irq)
        else $error("compare match flag not raised");

    // Further checks: no clear in normal mode, flag set and clear conditions
    a_normal_no_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_tick && !i_ctrl.count_wr && i_ctrl.wave_gen_mode == WGM_NORMAL
         && st.count == i_ctrl.cmp_value_a) |=> (o_stat.count_value == $past(st.count) + 8'h01))
        else $error("normal mode cleared on a match");

    a_clear_counts_up: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_tick && !i_ctrl.count_wr && i_ctrl.wave_gen_mode == WGM_CLEAR
         && st.count != i_ctrl.cmp_value_a) |=> (o_stat.count_value == $past(st.count) + 8'h01))
        else $error("clear mode did not count up below top");

    a_no_ovf_on_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ctrl.count_wr && !o_stat.overflow_flag) |=> !o_stat.overflow_flag)
        else $error("software write raised the overflow flag");

    a_ovf_only_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ctrl.wave_gen_mode == WGM_NORMAL && !o_stat.overflow_flag)
        |=> (!o_stat.overflow_flag || o_stat.count_value == CNT_BOTTOM))
        else $error("overflow flag set away from zero");

    a_ack_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_ctrl.overflow_ack && !i_tick) |=> (!o_stat.overflow_flag && !o_cmp_irq))
        else $error("acknowledge did not clear the flags");

    a_cmp_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (o_cmp_irq && !i_ctrl.overflow_ack) |=> o_cmp_irq)
        else $error("compare flag cleared without acknowledge");

    a_cmp_needs_match: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!match && !o_cmp_irq) |=> !o_cmp_irq)
        else $error("compare flag raised without a match");

    a_up_non_pwm: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_tick && !pwm) |=> st.up)
        else $error("single slope mode counted down");

endmodule : timer8_core
`default_nettype wire

//--- inc/timer8_pkg.sv
// Package: constants and carrier types for the 8-bit timer/counter
`default_nettype none
package timer8_pkg;

    localparam int          CNT_W      = 8;
    localparam logic [7:0]  CNT_BOTTOM = 8'h00;
    localparam logic [7:0]  CNT_MAX    = 8'hFF;
    localparam logic [7:0]  CNT_RST    = 8'h00;

    // Waveform generation mode codes
    localparam logic [2:0]  WGM_NORMAL = 3'h0;
    localparam logic [2:0]  WGM_PC_FF  = 3'h1;
    localparam logic [2:0]  WGM_CLEAR  = 3'h2;
    localparam logic [2:0]  WGM_FAST_FF = 3'h3;
    localparam logic [2:0]  WGM_PC_TOP = 3'h5;
    localparam logic [2:0]  WGM_FAST_TOP = 3'h7;

    // Compare output mode codes
    localparam logic [1:0]  COM_OFF    = 2'h0;
    localparam logic [1:0]  COM_TOGGLE = 2'h1;
    localparam logic [1:0]  COM_CLEAR  = 2'h2;
    localparam logic [1:0]  COM_SET    = 2'h3;

    // Software-side configuration and strobes
    typedef struct packed {
        logic [2:0] wave_gen_mode;
        logic [1:0] cmp_out_mode;
        logic [7:0] cmp_value_a;
        logic       count_wr;
        logic [7:0] count_wr_data;
        logic       force_cmp_strobe;
        logic       overflow_ack;
    } timer_ctrl_t;

    // Status seen by software
    typedef struct packed {
        logic [7:0] count_value;
        logic       overflow_flag;
        logic       cmp_match_flag;
        logic       cmp_out;
    } timer_stat_t;

endpackage : timer8_pkg
`default_nettype wire

//--- rtl/timer8_out_unit.sv
// Compare output unit: latches mode at match and drives the compare pin
`timescale 1ns/1ps
`default_nettype none
module timer8_out_unit
    import timer8_pkg::*;
(
    input  wire logic       i_clk,       // Timer clock
    input  wire logic       i_rst_n,     // Async reset, active low
    input  wire logic       i_pwm,       // PWM mode selected
    input  wire logic [1:0] i_mode,      // Requested compare output mode
    input  wire logic       i_match,     // Real compare match, tick qualified
    input  wire logic       i_force,     // Force-compare strobe
    input  wire logic       i_up,        // Counting direction (PWM)
    output logic            o_pin        // Compare output pin level
);

    typedef struct packed {
        logic [1:0] mode;
        logic       pin;
    } out_state_t;

    out_state_t st;
    out_state_t next_st;

    function automatic logic apply_action(input logic [1:0] m, input logic cur);
        unique case (m)
            COM_TOGGLE: apply_action = ~cur;
            COM_CLEAR:  apply_action = 1'b0;
            COM_SET:    apply_action = 1'b1;
            default:    apply_action = cur;
        endcase
    endfunction

    // The pin moves only at a match or a force, so a mode write shows at the next one
    always_comb
    begin
        next_st = st;
        if (i_match)
        begin
            // The mode standing now acts on this match; a stale copy would lag by one
            next_st.mode = i_mode;
            if (!i_pwm)
                next_st.pin = apply_action(i_mode, st.pin);
            else if (i_mode == COM_CLEAR)
                next_st.pin = ~i_up;
            else if (i_mode == COM_SET)
                next_st.pin = i_up;
        end
        else if (i_force && !i_pwm)
        begin
            // Forcing uses the requested mode at once, no match needed
            next_st.mode = i_mode;
            next_st.pin  = apply_action(i_mode, st.pin);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_pin = st.pin;

    a_force_sets_pin: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_force && !i_pwm && !i_match && i_mode == COM_SET) |=> o_pin)
        else $error("forced set did not raise the pin");

    a_mode_waits_match: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!i_match && !i_force) |=> (st.mode == $past(st.mode)))
        else $error("output mode changed without a match");

    a_match_new_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_match && !i_pwm && i_mode == COM_CLEAR) |=> !o_pin)
        else $error("match did not use the newly written mode");

    a_pwm_no_force: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_force && i_pwm && !i_match) |=> $stable(o_pin))
        else $error("force strobe acted in a PWM mode");

endmodule : timer8_out_unit
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking testbench for the 8-bit timer/counter core
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import timer8_pkg::*;
;
    typedef struct {
        logic [2:0] wgm;
        logic [1:0] com;
        logic [7:0] a, start, n, cnt;
        logic       ovf;
    } row_t;

    logic        i_clk, i_rst_n, i_tick;
    timer_ctrl_t ctrl;
    timer_stat_t stat;
    logic        ovf_irq, cmp_irq;
    int          n_fail, checked;
    logic        p;

    // Counting cases: mode, output mode, compare A, start, ticks -> count, overflow
    row_t rows[5] = '{
        '{WGM_NORMAL, COM_OFF,    8'h03, 8'hFE, 8'h03, 8'h01, 1'b1},
        '{WGM_NORMAL, COM_SET,    8'h03, 8'h00, 8'h05, 8'h05, 1'b0},
        '{WGM_CLEAR,  COM_OFF,    8'h03, 8'h00, 8'h05, 8'h01, 1'b0},
        '{WGM_CLEAR,  COM_TOGGLE, 8'h03, 8'h00, 8'h05, 8'h01, 1'b0},
        '{WGM_CLEAR,  COM_OFF,    8'h80, 8'h7E, 8'h04, 8'h01, 1'b0}};

    timer8_core u_dut (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_tick    (i_tick),
        .i_ctrl    (ctrl),
        .o_stat    (stat),
        .o_ovf_irq (ovf_irq),
        .o_cmp_irq (cmp_irq)
    );

    // 200 MHz clock
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Inputs change 1 ns after the edge; pulses last one cycle only
    task automatic step(input int n, input logic t);
        i_tick = t;
        repeat (n)
        begin
            @(posedge i_clk);
            #1;
            if (ctrl.count_wr) ctrl.count_wr = 1'b0;
            if (ctrl.force_cmp_strobe) ctrl.force_cmp_strobe = 1'b0;
            if (ctrl.overflow_ack) ctrl.overflow_ack = 1'b0;
        end
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Load the counter by a software write, no tick in that cycle
    task automatic load(input logic [7:0] v);
        ctrl.count_wr = 1'b1;
        ctrl.count_wr_data = v;
        step(1, 1'b0);
    endtask

    task automatic give_verdict();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog: the whole run needs well under 1000 cycles
    initial
    begin
        #20000;
        n_fail++;
        give_verdict();
    end

    initial
    begin
        n_fail = 0;
        checked = 0;
        i_rst_n = 1'b0;
        i_tick = 1'b0;
        ctrl = '0;
        repeat (10) @(posedge i_clk);
        #1;
        i_rst_n = 1'b1;
        chk({stat.count_value}, 8'h00, "reset count");
        chk({5'h0, stat.overflow_flag, stat.cmp_match_flag, stat.cmp_out}, 8'h00, "reset flags");
        $display("test reset done");

        // Table of counting sequences; flags cleared with the load
        foreach (rows[i])
        begin
            ctrl.wave_gen_mode = rows[i].wgm;
            ctrl.cmp_out_mode = rows[i].com;
            ctrl.cmp_value_a = rows[i].a;
            ctrl.overflow_ack = 1'b1;
            load(rows[i].start);
            step(rows[i].n, 1'b1);
            chk(stat.count_value, rows[i].cnt, "row count");
            chk({7'h0, stat.overflow_flag}, {7'h0, rows[i].ovf}, "row ovf");
        end
        $display("test table done");

        // Tick gating and writes while ticking
        ctrl.wave_gen_mode = WGM_NORMAL;
        load(8'h20);
        step(5, 1'b0);
        chk(stat.count_value, 8'h20, "hold without tick");
        step(3, 1'b1);
        chk(stat.count_value, 8'h23, "count on tick");
        ctrl.count_wr = 1'b1;
        ctrl.count_wr_data = 8'h55;
        step(1, 1'b1);
        chk(stat.count_value, 8'h55, "write beats tick");
        $display("test gating done");

        // Overflow flag is sticky; a wrap in the ack cycle wins
        load(8'hFF);
        ctrl.overflow_ack = 1'b1;
        step(1, 1'b1);
        chk({6'h0, stat.overflow_flag, ovf_irq}, 8'h03, "set beats ack");
        step(4, 1'b0);
        chk({7'h0, ovf_irq}, 8'h01, "flag sticky");
        ctrl.overflow_ack = 1'b1;
        step(1, 1'b0);
        chk({6'h0, stat.overflow_flag, ovf_irq}, 8'h00, "ack clears");
        $display("test overflow done");

        // Compare match request in normal mode
        ctrl.cmp_value_a = 8'h05;
        load(8'h05);
        chk({7'h0, cmp_irq}, 8'h00, "no match yet");
        step(1, 1'b1);
        chk({6'h0, stat.cmp_match_flag, cmp_irq}, 8'h03, "match irq");
        $display("test match done");

        // Compare output: force, deferred mode change, toggle
        ctrl.wave_gen_mode = WGM_CLEAR;
        ctrl.cmp_value_a = 8'h03;
        ctrl.cmp_out_mode = COM_SET;
        load(8'h00);
        ctrl.force_cmp_strobe = 1'b1;
        step(1, 1'b0);
        chk({7'h0, stat.cmp_out}, 8'h01, "force set");
        ctrl.cmp_out_mode = COM_CLEAR;
        step(3, 1'b0);
        chk({7'h0, stat.cmp_out}, 8'h01, "no effect before match");
        step(4, 1'b1);
        chk({7'h0, stat.cmp_out}, 8'h00, "clear at first match");
        ctrl.cmp_out_mode = COM_TOGGLE;
        step(8, 1'b1);
        p = stat.cmp_out;
        step(4, 1'b1);
        chk({7'h0, stat.cmp_out}, {7'h0, ~p}, "toggle on match");
        ctrl.force_cmp_strobe = 1'b1;
        step(1, 1'b0);
        chk({7'h0, stat.cmp_out}, {7'h0, p}, "force toggle");
        // A PWM mode ignores the strobe
        ctrl.wave_gen_mode = WGM_FAST_FF;
        step(1, 1'b0);
        ctrl.force_cmp_strobe = 1'b1;
        step(1, 1'b0);
        chk({7'h0, stat.cmp_out}, {7'h0, p}, "force refused in pwm");
        $display("test compare output done");

        // Reset in mid-run clears count, flags and pin; counting resumes at once
        ctrl.wave_gen_mode = WGM_CLEAR;
        ctrl.cmp_out_mode = COM_SET;
        step(5, 1'b1);
        chk({7'h0, stat.cmp_out}, 8'h01, "set on match");
        i_rst_n = 1'b0;
        step(1, 1'b1);
        chk(stat.count_value, 8'h00, "mid reset count");
        chk({5'h0, stat.overflow_flag, stat.cmp_match_flag, stat.cmp_out}, 8'h00, "mid reset flags");
        i_rst_n = 1'b1;
        step(1, 1'b1);
        chk(stat.count_value, 8'h01, "count after release");
        $display("test mid reset done");
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
